// ===== pkg/hlt_pkg.sv
package hlt_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [31:0] OFF_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFF_PERIOD = 32'h0000_0004;
  localparam logic [31:0] OFF_PWIDTH = 32'h0000_0008;
  localparam logic [31:0] OFF_STATUS = 32'h0000_000C;
  // ==========================================================
  // field positions
  localparam int CTRL_ON_BIT = 7;
  localparam int CTRL_MODE_LSB = 0;
  localparam int STAT_PWM_BIT = 8;
  localparam int STAT_RUN_BIT = 9;
  localparam int CNT_W = 8;
  // ==========================================================
  // reset values
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] PWIDTH_RST = 8'h00;
  // ==========================================================
  // mode families and sub-modes
  localparam logic [1:0] FAM_FREE = 2'h0;
  localparam logic [1:0] FAM_ONESHOT = 2'h1;
  localparam logic [2:0] SUB_SOFT = 3'h0;
  localparam logic [2:0] SUB_001 = 3'h1;
  localparam logic [2:0] SUB_010 = 3'h2;
  localparam logic [2:0] SUB_011 = 3'h3;
  localparam logic [2:0] SUB_100 = 3'h4;
  localparam logic [2:0] SUB_101 = 3'h5;
  localparam logic [2:0] SUB_110 = 3'h6;
  localparam logic [2:0] SUB_111 = 3'h7;
  // ==========================================================
  // bus answers and register selector codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_PERIOD = 3'h1;
  localparam logic [2:0] SEL_PWIDTH = 3'h2;
  localparam logic [2:0] SEL_STATUS = 3'h3;
  localparam logic [2:0] SEL_NONE = 3'h7;

  // ==========================================================
  // whole block state
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic rvalid;
    logic aw_got;
    logic w_got;
    logic [2:0] wsel;
    logic [7:0] wbyte;
    logic wlane;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic on;
    logic [4:0] mode;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] pwidth;
    logic [CNT_W-1:0] count;
    logic ers_prev;
    logic started;
    logic pwm;
  } hlt_state_t;
endpackage : hlt_pkg

// ===== rtl/hlt_timer.sv
// Added by the designer: register access over AXI4-Lite and the register addresses.
module hlt_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic external_reset_signal,
  input wire logic debug_mode,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pwm_out,
  output logic [hlt_pkg::CNT_W-1:0] timer_count
);

  hlt_pkg::hlt_state_t r_reg;
  hlt_pkg::hlt_state_t r_next;
  logic ers_eff;
  logic rise;
  logic fall;
  logic run;
  logic clr;
  logic start_ev;
  logic hold;
  logic wr_fire;
  logic [1:0] fam;
  logic [2:0] sub;

  // ==========================================================
  // address decode, shared by read and write
  function automatic logic [2:0] sel_of(input logic [31:0] a);
    case (a)
      hlt_pkg::OFF_CTRL: sel_of = hlt_pkg::SEL_CTRL;
      hlt_pkg::OFF_PERIOD: sel_of = hlt_pkg::SEL_PERIOD;
      hlt_pkg::OFF_PWIDTH: sel_of = hlt_pkg::SEL_PWIDTH;
      hlt_pkg::OFF_STATUS: sel_of = hlt_pkg::SEL_STATUS;
      default: sel_of = hlt_pkg::SEL_NONE;
    endcase
  endfunction : sel_of

  // ==========================================================
  // trigger conditioning: debug freezes the last seen level
  assign ers_eff = debug_mode ? r_reg.ers_prev : external_reset_signal;
  assign rise = ers_eff & ~r_reg.ers_prev;
  assign fall = ~ers_eff & r_reg.ers_prev;
  assign fam = r_reg.mode[4:3];
  assign sub = r_reg.mode[2:0];
  assign wr_fire = r_reg.aw_got & r_reg.w_got & ~r_reg.bvalid;

  // ==========================================================
  // mode decode into run, clear, hold and start terms
  always_comb begin
    run = 1'b0;
    clr = 1'b0;
    hold = 1'b0;
    start_ev = 1'b0;
    if (fam == hlt_pkg::FAM_FREE) begin
      case (sub)
        hlt_pkg::SUB_SOFT: run = r_reg.on;
        hlt_pkg::SUB_001: run = r_reg.on & ers_eff;
        hlt_pkg::SUB_010: run = r_reg.on & ~ers_eff;
        hlt_pkg::SUB_011: begin
          run = r_reg.on;
          clr = rise | fall;
        end
        hlt_pkg::SUB_100: begin
          run = r_reg.on;
          clr = rise;
        end
        hlt_pkg::SUB_101: begin
          run = r_reg.on;
          clr = fall;
        end
        hlt_pkg::SUB_110: begin
          run = r_reg.on & ers_eff;
          clr = ~ers_eff;
        end
        hlt_pkg::SUB_111: begin
          run = r_reg.on & ~ers_eff;
          clr = ers_eff;
        end
        default: run = 1'b0;
      endcase
    end else if (fam == hlt_pkg::FAM_ONESHOT) begin
      case (sub)
        hlt_pkg::SUB_SOFT: start_ev = 1'b1;
        hlt_pkg::SUB_001: start_ev = rise;
        hlt_pkg::SUB_010: start_ev = fall;
        hlt_pkg::SUB_011: start_ev = rise | fall;
        hlt_pkg::SUB_100: start_ev = rise;
        hlt_pkg::SUB_101: start_ev = fall;
        hlt_pkg::SUB_110: begin
          start_ev = rise;
          hold = ~ers_eff;
        end
        hlt_pkg::SUB_111: begin
          start_ev = fall;
          hold = ers_eff;
        end
        default: start_ev = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // next-state: timer core then bus slave
  always_comb begin
    r_next = r_reg;
    r_next.ers_prev = ers_eff;
    // timer core
    if (fam == hlt_pkg::FAM_FREE) begin
      r_next.started = 1'b0;
      if (clr) begin
        r_next.count = '0;
      end else if (run) begin
        if (r_reg.count == r_reg.period) begin
          r_next.count = '0;
          r_next.pwm = 1'b1;
        end else begin
          r_next.count = r_reg.count + 1'b1;
        end
        if (r_reg.count == r_reg.pwidth) begin
          r_next.pwm = 1'b0;
        end
      end
    end else if (fam == hlt_pkg::FAM_ONESHOT) begin
      if (!r_reg.on) begin
        r_next.started = 1'b0;
      end else if (r_reg.started) begin
        if (r_reg.count == r_reg.pwidth) begin
          r_next.pwm = 1'b0;
        end
        if (r_reg.count == r_reg.period) begin
          r_next.count = '0;
          r_next.on = 1'b0;
          r_next.started = 1'b0;
        end else begin
          r_next.count = r_reg.count + 1'b1;
        end
      end else if (start_ev) begin
        r_next.started = 1'b1;
        r_next.pwm = 1'b1;
      end
      if (hold) begin
        r_next.count = '0;
      end
    end else begin
      r_next.started = 1'b0;
    end
    // write address and data, taken in either order
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.aw_got = 1'b1;
      r_next.wsel = sel_of(s_axi_awaddr);
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.w_got = 1'b1;
      r_next.wbyte = s_axi_wdata[7:0];
      r_next.wlane = s_axi_wstrb[0];
    end
    // register write; a software set of on wins over hardware clear
    if (wr_fire) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = hlt_pkg::RESP_OKAY;
      case (r_reg.wsel)
        hlt_pkg::SEL_CTRL: begin
          if (r_reg.wlane) begin
            r_next.on = r_reg.wbyte[hlt_pkg::CTRL_ON_BIT];
            r_next.mode = r_reg.wbyte[hlt_pkg::CTRL_MODE_LSB +: 5];
          end
        end
        hlt_pkg::SEL_PERIOD: begin
          if (r_reg.wlane) begin
            r_next.period = r_reg.wbyte;
          end
        end
        hlt_pkg::SEL_PWIDTH: begin
          if (r_reg.wlane) begin
            r_next.pwidth = r_reg.wbyte;
          end
        end
        hlt_pkg::SEL_STATUS: r_next.bresp = hlt_pkg::RESP_OKAY;
        default: r_next.bresp = hlt_pkg::RESP_SLVERR;
      endcase
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    // read channel: one read at a time
    if (s_axi_arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = hlt_pkg::RESP_OKAY;
      r_next.rdata = '0;
      case (sel_of(s_axi_araddr))
        hlt_pkg::SEL_CTRL: begin
          r_next.rdata[hlt_pkg::CTRL_ON_BIT] = r_reg.on;
          r_next.rdata[hlt_pkg::CTRL_MODE_LSB +: 5] = r_reg.mode;
        end
        hlt_pkg::SEL_PERIOD: r_next.rdata[7:0] = r_reg.period;
        hlt_pkg::SEL_PWIDTH: r_next.rdata[7:0] = r_reg.pwidth;
        hlt_pkg::SEL_STATUS: begin
          r_next.rdata[7:0] = r_reg.count;
          r_next.rdata[hlt_pkg::STAT_PWM_BIT] = r_reg.pwm;
          r_next.rdata[hlt_pkg::STAT_RUN_BIT] = r_reg.started;
        end
        default: r_next.rresp = hlt_pkg::RESP_SLVERR;
      endcase
    end else if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    r_next.awready = ~r_next.aw_got & ~r_next.bvalid;
    r_next.wready = ~r_next.w_got & ~r_next.bvalid;
    r_next.arready = ~r_next.rvalid;
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.mode <= hlt_pkg::MODE_RST;
      r_reg.period <= hlt_pkg::PERIOD_RST;
      r_reg.pwidth <= hlt_pkg::PWIDTH_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready = r_reg.wready;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign s_axi_rvalid = r_reg.rvalid;
  assign pwm_out = r_reg.pwm;
  assign timer_count = r_reg.count;

  // ==========================================================
  // checks
  property p_debug_freeze;
    @(posedge core_clk) disable iff (rst)
      debug_mode |=> $stable(r_reg.ers_prev);
  endproperty
  a_debug_freeze: assert property (p_debug_freeze)
    else $error("trigger level moved in debug mode");

  property p_gate_high;
    @(posedge core_clk) disable iff (rst)
      (r_reg.mode == 5'h01) && !debug_mode && !external_reset_signal
        |=> $stable(r_reg.count);
  endproperty
  a_gate_high: assert property (p_gate_high)
    else $error("active-high gate counted while low");

  property p_gate_low;
    @(posedge core_clk) disable iff (rst)
      (r_reg.mode == 5'h02) && !debug_mode && external_reset_signal
        |=> $stable(r_reg.count);
  endproperty
  a_gate_low: assert property (p_gate_low)
    else $error("active-low gate counted while high");

  property p_any_edge_reset;
    @(posedge core_clk) disable iff (rst)
      (r_reg.mode == 5'h03) && !debug_mode
        && (external_reset_signal != r_reg.ers_prev) |=> r_reg.count == '0;
  endproperty
  a_any_edge_reset: assert property (p_any_edge_reset)
    else $error("edge did not reset count");

  property p_level_hold;
    @(posedge core_clk) disable iff (rst)
      (r_reg.mode == 5'h07) && !debug_mode && external_reset_signal
        |=> r_reg.count == '0;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("count not held at reset level");

  property p_oneshot_end;
    @(posedge core_clk) disable iff (rst)
      (fam == hlt_pkg::FAM_ONESHOT) && r_reg.on && r_reg.started && !hold
        && (r_reg.count == r_reg.period) |=> (r_reg.count == '0) && !r_reg.started;
  endproperty
  a_oneshot_end: assert property (p_oneshot_end)
    else $error("one-shot did not end at period match");

  property p_pwm_start;
    @(posedge core_clk) disable iff (rst)
      (r_reg.mode == 5'h0E) && r_reg.on && !r_reg.started && !debug_mode
        && external_reset_signal && !r_reg.ers_prev |=> r_reg.pwm && r_reg.started;
  endproperty
  a_pwm_start: assert property (p_pwm_start)
    else $error("pwm not active at starting edge");

  property p_no_reactivate;
    @(posedge core_clk) disable iff (rst)
      (fam == hlt_pkg::FAM_ONESHOT) && r_reg.started && r_reg.on
        && (r_reg.count == r_reg.period) && (r_reg.count != r_reg.pwidth)
        |=> r_reg.pwm == $past(r_reg.pwm);
  endproperty
  a_no_reactivate: assert property (p_no_reactivate)
    else $error("period match changed pwm");

  property p_increment;
    @(posedge core_clk) disable iff (rst)
      (r_reg.mode == 5'h00) && r_reg.on && (r_reg.count != r_reg.period)
        |=> r_reg.count == $past(r_reg.count) + 8'h01;
  endproperty
  a_increment: assert property (p_increment)
    else $error("count did not step by one");

endmodule : hlt_timer

// ===== sim/hlt_ext_src.sv
// ==========================================================
// far-side source of the external reset and trigger level
module hlt_ext_src (
  input wire logic core_clk,
  output logic external_reset_signal
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam time MIN_GAP_NS = 300;
  time last_t = 0;
  initial external_reset_signal = 1'b0;

  // the next level change waits for the minimum spacing, so every level lasts long enough
  task automatic move(input logic v);
    while ($time - last_t < MIN_GAP_NS) @(posedge core_clk);
    external_reset_signal <= v;
    last_t = $time;
  endtask : move
endmodule : hlt_ext_src

// ===== sim/hardware_limit_timer_modes_test.sv
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module hardware_limit_timer_modes_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic debug_mode = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic pwm_out, external_reset_signal;
  logic [hlt_pkg::CNT_W-1:0] timer_count, c;
  int n_errors = 0;
  int comparisons = 0;
  int i, m;
  logic lvl;

  // ==========================================================
  // clock, design and far-side source
  initial forever #25 core_clk = ~core_clk;
  hlt_timer dut (
    .core_clk(core_clk),
    .rst(rst),
    .external_reset_signal(external_reset_signal),
    .debug_mode(debug_mode),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .pwm_out(pwm_out),
    .timer_count(timer_count)
  );
  hlt_ext_src src (
    .core_clk(core_clk),
    .external_reset_signal(external_reset_signal)
  );

  // ==========================================================
  // shared tasks
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // a wait that runs out ends the run as a mismatch
  task automatic hang;
    n_errors++;
    complete_run();
  endtask : hang
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 40) hang();
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rdreg(input logic [31:0] a);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 40) hang();
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask : rdreg
  task automatic waitcnt(input logic [7:0] v);
    int k;
    for (k = 0; k < 600 && timer_count !== v; k++) @(posedge core_clk);
    if (k == 600) hang();
  endtask : waitcnt

  // ==========================================================
  // scenarios
  task automatic t_regs;
    rdreg(hlt_pkg::OFF_CTRL);
    `CHK(rd, 32'h0000_0000)
    rdreg(hlt_pkg::OFF_PERIOD);
    `CHK(rd, 32'h0000_00FF)
    rdreg(32'h0000_0010);
    `CHK(rsp, hlt_pkg::RESP_SLVERR)
    rdreg(hlt_pkg::OFF_PWIDTH);
    `CHK(rd, 32'h0000_0000)
    wr(32'h0000_0010, 8'h00);
    `CHK(rsp, hlt_pkg::RESP_SLVERR)
    wr(hlt_pkg::OFF_STATUS, 8'h55);
    `CHK(rsp, hlt_pkg::RESP_OKAY)
    rdreg(hlt_pkg::OFF_STATUS);
    `CHK(rd, 32'h0000_0000)
    $display("register test done");
  endtask : t_regs
  task automatic t_free;
    wr(hlt_pkg::OFF_PERIOD, 8'h04);
    wr(hlt_pkg::OFF_CTRL, 8'h80);
    waitcnt(8'h04);
    tick(1);
    `CHK(timer_count, 8'h00)
    tick(1);
    `CHK(timer_count, 8'h01)
    wr(hlt_pkg::OFF_CTRL, 8'h90);
    c = timer_count;
    tick(4);
    `CHK(timer_count, c)
    wr(hlt_pkg::OFF_CTRL, 8'h00);
    $display("free-run test done");
  endtask : t_free
  // gate modes: stopped at the wrong level, running at the right one
  task automatic t_gate;
    wr(hlt_pkg::OFF_PERIOD, 8'hFF);
    for (m = 1; m <= 2; m++) begin
      src.move(m == 2);
      wr(hlt_pkg::OFF_CTRL, {5'h10, m[2:0]});
      c = timer_count;
      tick(4);
      `CHK(timer_count, c)
      src.move(m == 1);
      tick(4);
      `CHK(timer_count != c, 1'b1)
      wr(hlt_pkg::OFF_CTRL, 8'h00);
    end
    $display("gate test done");
  endtask : t_gate
  // edge reset modes: the wanted edge clears the count, the other one too in mode 3 only
  task automatic t_edge;
    for (m = 3; m <= 5; m++) begin
      lvl = (m == 5);
      src.move(lvl);
      wr(hlt_pkg::OFF_CTRL, {5'h10, m[2:0]});
      tick(12);
      src.move(!lvl);
      tick(3);
      `CHK(timer_count <= 8'h03, 1'b1)
      tick(8);
      src.move(lvl);
      tick(3);
      `CHK(timer_count <= 8'h03, m == 3)
      wr(hlt_pkg::OFF_CTRL, 8'h00);
    end
    $display("edge reset test done");
  endtask : t_edge
  task automatic t_debug;
    src.move(1'b0);
    wr(hlt_pkg::OFF_CTRL, 8'h84);
    debug_mode <= 1'b1;
    tick(12);
    src.move(1'b1);
    tick(3);
    `CHK(timer_count > 8'h03, 1'b1)
    wr(hlt_pkg::OFF_CTRL, 8'h00);
    debug_mode <= 1'b0;
    $display("debug test done");
  endtask : t_debug
  task automatic t_level;
    for (m = 6; m <= 7; m++) begin
      src.move(m == 7);
      wr(hlt_pkg::OFF_CTRL, {5'h10, m[2:0]});
      tick(4);
      `CHK(timer_count, 8'h00)
      src.move(m != 7);
      tick(6);
      `CHK(timer_count > 8'h02, 1'b1)
      wr(hlt_pkg::OFF_CTRL, 8'h00);
    end
    $display("level reset test done");
  endtask : t_level
  task automatic t_os_sw;
    wr(hlt_pkg::OFF_CTRL, 8'h88);
    waitcnt(8'hFF);
    tick(1);
    `CHK(timer_count, 8'h00)
    tick(4);
    `CHK(timer_count, 8'h00)
    rdreg(hlt_pkg::OFF_CTRL);
    `CHK(rd, 32'h0000_0008)
    $display("one-shot software test done");
  endtask : t_os_sw
  // edge started one-shot: idle before the edge, no restart without a new edge
  task automatic t_os_edge;
    wr(hlt_pkg::OFF_PERIOD, 8'h05);
    for (m = 9; m <= 15; m++) begin
      lvl = (m == 10) || (m == 13) || (m == 15);
      src.move(lvl);
      wr(hlt_pkg::OFF_CTRL, {3'h4, m[4:0]});
      tick(4);
      `CHK(timer_count, 8'h00)
      src.move(!lvl);
      waitcnt(8'h05);
      tick(3);
      `CHK(timer_count, 8'h00)
      wr(hlt_pkg::OFF_CTRL, {3'h4, m[4:0]});
      tick(6);
      `CHK(timer_count, 8'h00)
      wr(hlt_pkg::OFF_CTRL, 8'h00);
    end
    $display("one-shot edge test done");
  endtask : t_os_edge
  task automatic t_pwm;
    wr(hlt_pkg::OFF_PWIDTH, 8'h02);
    wr(hlt_pkg::OFF_PERIOD, 8'h06);
    src.move(1'b0);
    wr(hlt_pkg::OFF_CTRL, 8'h8E);
    tick(4);
    `CHK(timer_count, 8'h00)
    src.move(1'b1);
    for (i = 0; i < 4 && pwm_out !== 1'b1; i++) tick(1);
    `CHK(pwm_out, 1'b1)
    rdreg(hlt_pkg::OFF_STATUS);
    `CHK(rd[9:8], 2'h3)
    waitcnt(8'h06);
    `CHK(pwm_out, 1'b0)
    tick(3);
    `CHK(pwm_out, 1'b0)
    `CHK(timer_count, 8'h00)
    rdreg(hlt_pkg::OFF_STATUS);
    `CHK(rd, 32'h0000_0000)
    rdreg(hlt_pkg::OFF_CTRL);
    `CHK(rd, 32'h0000_000E)
    $display("pwm one-shot test done");
  endtask : t_pwm

  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    t_regs();
    t_free();
    t_gate();
    t_edge();
    t_debug();
    t_level();
    t_os_sw();
    t_os_edge();
    t_pwm();
    complete_run();
  end
endmodule : hardware_limit_timer_modes_test
